// ### hw/qei_core.sv
// Summary of operation
// - four interrupt sources in one field
// - clear-by-mask drops selected sources only
// - enable mask gates sources onto interrupt
// - read raw or masked interrupt status
// - position counter always readable
// - position write reloads counter
// - unaligned until first index in index mode
// - predivide increments by 1 to 128
// - accumulate over period, save, restart
// - velocity capture has own enable
// - no velocity capture while encoder disabled
// - last completed velocity count readable
// - simultaneous phase change flags error
// - phase and clock/direction modes
// - index resets to max reverse, else zero
// - events set matching interrupt sources
`timescale 1ns/10ps
`default_nettype none
`include "qei_regs.svh"
module qei_core #(
  parameter int PRED_W = 3  // predivide select width, 2**7 = 128 top
) (
  input  wire logic                  clock_i,
  input  wire logic                  rst_n_i,
  input  wire qei_pkg::qei_bus_req_s bus_i,
  output logic [31:0]                rdata_o,
  input  wire qei_pkg::qei_enc_in_s  pins_i,
  output logic                       irq_o,
  output logic                       direction_o,
  output logic [31:0]                position_o
);
  import qei_pkg::*;

  typedef struct packed {
    logic [5:0]        ctrl;        // enable, vel enable, modes
    logic [31:0]       pos;         // position counter
    logic [31:0]       maxpos;      // max position value
    logic [PRED_W-1:0] prediv;      // log2 of predivide
    logic [31:0]       period;      // velocity period ticks
    logic [31:0]       tick_cnt;    // ticks left in period
    logic [7:0]        div_cnt;     // predivider counter
    logic [31:0]       vel_acc;     // running velocity count
    logic [31:0]       vel_res;     // completed period count
    qei_irq_t          irq_en;      // enable mask
    qei_irq_t          irq_raw;     // sticky raw status
    logic              err_flag;    // phase error indicator
    logic              dir;         // 1 = reverse
    logic              dir_valid;   // a direction has been seen
    logic              aligned;     // index seen since mode set
    logic              irq;         // registered interrupt
    logic [31:0]       rdata;       // read data register
  } qei_state_s;

  qei_state_s   st_reg;   // registered state
  qei_state_s   st_next;  // next state
  qei_dec_out_s ev;       // decoder events
  logic         enc_en;   // encoder running
  logic         vel_run;  // velocity capture running
  logic [7:0]   div_max;  // predivide terminal count
  qei_irq_t     set_v;    // events this cycle

  qei_decoder u_dec (
    .clock_i    (clock_i),
    .rst_n_i    (rst_n_i),
    .pins_i     (pins_i),
    .step_dir_i (st_reg.ctrl[`QEI_CTRL_STEPDIR]),
    .cap_ab_i   (st_reg.ctrl[`QEI_CTRL_CAP_AB]),
    .swap_i     (st_reg.ctrl[`QEI_CTRL_SWAP]),
    .ev_o       (ev)
  );

  assign enc_en  = st_reg.ctrl[`QEI_CTRL_ENABLE];
  // velocity needs both enables
  assign vel_run = enc_en & st_reg.ctrl[`QEI_CTRL_VEL_EN];
  // divide by 2**prediv: 1,2,4..128
  assign div_max = 8'((9'h001 << st_reg.prediv) - 9'h001);

  assign rdata_o     = st_reg.rdata;
  assign irq_o       = st_reg.irq;
  assign direction_o = st_reg.dir;
  assign position_o  = st_reg.pos;

  // all block behaviour in one pass
  always_comb begin
    st_next = st_reg;
    set_v   = '0;

    // position integrator, only while enabled
    if (enc_en && ev.step) begin
      if (ev.reverse) begin
        st_next.pos = (st_reg.pos == 32'h00000000) ? st_reg.maxpos : st_reg.pos - 32'h00000001;
      end else begin
        st_next.pos = (st_reg.pos >= st_reg.maxpos) ? 32'h00000000 : st_reg.pos + 32'h00000001;
      end
      // direction held while stationary
      st_next.dir       = ev.reverse;
      st_next.dir_valid = 1'b1;
      if (st_reg.dir_valid && (ev.reverse != st_reg.dir)) begin
        set_v[`QEI_IRQ_DIR] = 1'b1;
      end
    end
    if (enc_en && ev.error) begin
      st_next.err_flag      = 1'b1;
      set_v[`QEI_IRQ_ERROR] = 1'b1;
    end
    if (enc_en && ev.index) begin
      set_v[`QEI_IRQ_INDEX] = 1'b1;
      if (st_reg.ctrl[`QEI_CTRL_RST_IDX]) begin
        // only now is the counter aligned
        st_next.aligned = 1'b1;
        st_next.pos     = st_reg.dir ? st_reg.maxpos : 32'h00000000;
      end
    end

    // velocity capture
    if (vel_run) begin
      if (ev.step) begin
        // predivided increment feeds accumulator
        if (st_reg.div_cnt >= div_max) begin
          st_next.div_cnt = 8'h00;
          st_next.vel_acc = st_reg.vel_acc + 32'h00000001;
        end else begin
          st_next.div_cnt = st_reg.div_cnt + 8'h01;
        end
      end
      if (st_reg.tick_cnt <= 32'h00000001) begin
        // period over: save, restart
        st_next.vel_res       = st_next.vel_acc;
        st_next.vel_acc       = 32'h00000000;
        st_next.tick_cnt      = st_reg.period;  // a zero period acts as one
        set_v[`QEI_IRQ_TIMER] = 1'b1;
      end else begin
        st_next.tick_cnt = st_reg.tick_cnt - 32'h00000001;
      end
    end else begin
      // idle: reload so a fresh enable starts a full period
      st_next.tick_cnt = st_reg.period;
      st_next.div_cnt  = 8'h00;
      st_next.vel_acc  = 32'h00000000;
    end

    // register writes
    if (bus_i.wr) begin
      case (bus_i.addr)
        `QEI_OFF_CTRL: begin
          st_next.ctrl = bus_i.wdata[5:0];
          if (bus_i.wdata[`QEI_CTRL_RST_IDX] && !st_reg.ctrl[`QEI_CTRL_RST_IDX]) begin
            st_next.aligned = 1'b0;
          end
        end
        `QEI_OFF_STATUS: begin
          if (bus_i.wdata[`QEI_STAT_ERROR]) begin
            st_next.err_flag = 1'b0;
          end
        end
        `QEI_OFF_POS:    st_next.pos    = bus_i.wdata;
        `QEI_OFF_MAXPOS: st_next.maxpos = bus_i.wdata;
        `QEI_OFF_VELCFG: st_next.prediv = bus_i.wdata[PRED_W-1:0];
        `QEI_OFF_VELPER: st_next.period = bus_i.wdata;
        `QEI_OFF_INT_EN:  st_next.irq_en = st_reg.irq_en | bus_i.wdata[3:0];
        `QEI_OFF_INT_DIS: st_next.irq_en = st_reg.irq_en & ~bus_i.wdata[3:0];
        `QEI_OFF_INT_CLR: st_next.irq_raw = st_reg.irq_raw & ~bus_i.wdata[3:0];
        default: begin
          // unmapped or read-only: write ignored
        end
      endcase
    end
    // error event wins over a same-cycle clear
    if (enc_en && ev.error) begin
      st_next.err_flag = 1'b1;
    end
    // sticky, set wins over clear
    st_next.irq_raw = st_next.irq_raw | set_v;
    // only enabled sources reach the line
    st_next.irq = |(st_next.irq_raw & st_next.irq_en);

    // read data, valid in the cycle after the strobe
    st_next.rdata = 32'h00000000;
    if (bus_i.rd) begin
      case (bus_i.addr)
        `QEI_OFF_CTRL:    st_next.rdata = {26'h0000000, st_reg.ctrl};
        `QEI_OFF_STATUS:  st_next.rdata = {29'h00000000, st_reg.aligned, st_reg.dir, st_reg.err_flag};
        `QEI_OFF_POS:     st_next.rdata = st_reg.pos;
        `QEI_OFF_MAXPOS:  st_next.rdata = st_reg.maxpos;
        `QEI_OFF_VELCFG:  st_next.rdata = {{(32-PRED_W){1'b0}}, st_reg.prediv};
        `QEI_OFF_VELPER:  st_next.rdata = st_reg.period;
        `QEI_OFF_VELRES:  st_next.rdata = st_reg.vel_res;
        `QEI_OFF_VELACC:  st_next.rdata = st_reg.vel_acc;
        `QEI_OFF_INT_EN:  st_next.rdata = {28'h0000000, st_reg.irq_en};
        `QEI_OFF_INT_RAW: st_next.rdata = {28'h0000000, st_reg.irq_raw};
        `QEI_OFF_INT_MSK: st_next.rdata = {28'h0000000, st_reg.irq_raw & st_reg.irq_en};
        default:          st_next.rdata = 32'h00000000;  // unmapped reads zero
      endcase
    end
  end

  // single state register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg        <= '0;
      st_reg.ctrl   <= `QEI_RST_CTRL;
      st_reg.maxpos <= `QEI_RST_MAXPOS;
      st_reg.period <= `QEI_RST_VELPER;
      st_reg.prediv <= PRED_W'(`QEI_RST_PREDIV);
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : qei_core
`default_nettype wire

// ### hw/qei_regs.svh
`ifndef QEI_REGS_SVH
`define QEI_REGS_SVH
// register offsets (byte addresses, one word each)
`define QEI_OFF_CTRL      8'h00
`define QEI_OFF_STATUS    8'h04
`define QEI_OFF_POS       8'h08
`define QEI_OFF_MAXPOS    8'h0C
`define QEI_OFF_VELCFG    8'h10
`define QEI_OFF_VELPER    8'h14
`define QEI_OFF_VELRES    8'h18
`define QEI_OFF_VELACC    8'h1C
`define QEI_OFF_INT_EN    8'h20
`define QEI_OFF_INT_DIS   8'h24
`define QEI_OFF_INT_RAW   8'h28
`define QEI_OFF_INT_MSK   8'h2C
`define QEI_OFF_INT_CLR   8'h30
// control field positions
`define QEI_CTRL_ENABLE   0
`define QEI_CTRL_VEL_EN   1
`define QEI_CTRL_RST_IDX  2
`define QEI_CTRL_STEPDIR  3
`define QEI_CTRL_CAP_AB   4
`define QEI_CTRL_SWAP     5
// status field positions
`define QEI_STAT_ERROR    0
`define QEI_STAT_DIR      1
// interrupt bit positions
`define QEI_IRQ_INDEX     0
`define QEI_IRQ_TIMER     1
`define QEI_IRQ_DIR       2
`define QEI_IRQ_ERROR     3
// reset values
`define QEI_RST_CTRL      6'h00
`define QEI_RST_MAXPOS    32'hFFFFFFFF
`define QEI_RST_VELPER    32'h00000001
`define QEI_RST_PREDIV    3'h0
`endif

// ### hw/qei_pkg.sv
package qei_pkg;
  typedef logic [3:0] qei_irq_t;   // index, timer, dir, error
  typedef struct packed {
    logic [7:0]  addr;   // byte address
    logic [31:0] wdata;  // write data
    logic        wr;     // write strobe
    logic        rd;     // read strobe
  } qei_bus_req_s;
  typedef struct packed {
    logic a;       // channel a or step clock
    logic b;       // channel b or direction level
    logic index;   // index pulse
  } qei_enc_in_s;
  typedef struct packed {
    logic step;     // one position increment
    logic reverse;  // direction of that increment
    logic error;    // both phases changed together
    logic index;    // index rising edge
  } qei_dec_out_s;
endpackage : qei_pkg

// ### hw/qei_decoder.sv
`timescale 1ns/10ps
`default_nettype none
// turns raw encoder pins into step, direction, error and index events
module qei_decoder (
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  input  wire qei_pkg::qei_enc_in_s pins_i,
  input  wire logic                 step_dir_i,  // clock/direction mode
  input  wire logic                 cap_ab_i,    // count both channels
  input  wire logic                 swap_i,      // swap a and b
  output var qei_pkg::qei_dec_out_s ev_o
);
  import qei_pkg::*;

  typedef struct packed {
    logic         a;
    logic         b;
    logic         idx;
    qei_dec_out_s ev;
  } qei_dec_state_s;

  qei_dec_state_s st_reg;   // registered state
  qei_dec_state_s st_next;  // next state
  logic           a_in;     // after optional swap
  logic           b_in;

  assign a_in = swap_i ? pins_i.b : pins_i.a;
  assign b_in = swap_i ? pins_i.a : pins_i.b;
  assign ev_o = st_reg.ev;

  // edge detection; events last one cycle
  always_comb begin
    st_next       = st_reg;
    st_next.a     = a_in;
    st_next.b     = b_in;
    st_next.idx   = pins_i.index;
    st_next.ev    = '0;
    st_next.ev.index = pins_i.index & ~st_reg.idx;
    if (step_dir_i) begin
      // rising step edge counts, b is the direction level
      st_next.ev.step    = a_in & ~st_reg.a;
      st_next.ev.reverse = b_in;
    end else if ((a_in != st_reg.a) && (b_in != st_reg.b)) begin
      // both phases moved at once: direction unknown, no count
      st_next.ev.error = 1'b1;
    end else if (a_in != st_reg.a) begin
      // a edge: leads b when a != b after the edge
      st_next.ev.step    = 1'b1;
      st_next.ev.reverse = (a_in == b_in);
    end else if ((b_in != st_reg.b) && cap_ab_i) begin
      st_next.ev.step    = 1'b1;
      st_next.ev.reverse = (a_in != b_in);
    end
  end

  // constant reset; pins sampled only after release
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : qei_decoder
`default_nettype wire

// ### verification/qepv_enc_model.sv
`timescale 1ns/10ps
`default_nettype none
// behavioural encoder: quadrature pair or step/direction, plus index
module qepv_enc_model (
  input  wire logic                 clock_i,
  input  wire logic                 phase_mode_i, // 1 = quadrature pair
  input  wire logic                 step_i,       // one increment request
  input  wire logic                 rev_i,        // reverse motion
  input  wire logic                 glitch_i,     // both phases at once
  input  wire logic                 index_i,      // index request
  output wire qei_pkg::qei_enc_in_s pins_o
);
  import qei_pkg::*;
  logic [1:0] gray_reg  = 2'h0; // quadrature phase state
  logic       pulse_reg = 1'b0; // step clock, one cycle high
  logic       index_reg = 1'b0; // index pin level
  // one channel moves per step; a glitch jumps two states so both move
  always @(posedge clock_i) begin
    pulse_reg <= step_i && !phase_mode_i;
    index_reg <= index_i;
    if (glitch_i) begin
      gray_reg <= gray_reg + 2'h2;
    end else if (step_i && phase_mode_i) begin
      gray_reg <= rev_i ? gray_reg - 2'h1 : gray_reg + 2'h1;
    end
  end
  // direction level is set a cycle before the step clock rises
  assign pins_o = '{phase_mode_i ? gray_reg[1] : pulse_reg, phase_mode_i ? ^gray_reg : rev_i, index_reg};
endmodule : qepv_enc_model
`default_nettype wire

// ### verification/qepv_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// port-level checks on the encoder core
module qepv_asserts #(
  parameter int PRED_W = 3  // predivide select width
) (
  input wire logic                  clock_i,
  input wire logic                  rst_n_i,
  input wire qei_pkg::qei_bus_req_s bus_i,
  input wire logic [31:0]           rdata_o,
  input wire qei_pkg::qei_enc_in_s  pins_i,
  input wire logic                  irq_o,
  input wire logic                  direction_o,
  input wire logic [31:0]           position_o
);
  import qei_pkg::*;
  logic en_reg; // last written encoder enable
  // shadow of the enable bit, from control writes
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_reg <= 1'b0;
    end else if (bus_i.wr && bus_i.addr == 8'h00) begin
      en_reg <= bus_i.wdata[0];
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  chk_rdata_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 32'h0)
    else $error("read data not zero outside read slot");
  chk_pos_write: assert property (bus_i.wr && bus_i.addr == 8'h08 |=> position_o == $past(bus_i.wdata))
    else $error("position write not loaded");
  chk_pos_read: assert property (bus_i.rd && bus_i.addr == 8'h08 |=> rdata_o == $past(position_o))
    else $error("position read differs from counter");
  chk_irq_width: assert property (bus_i.rd && bus_i.addr[7:3] == 5'h05 |=> rdata_o[31:4] == 28'h0)
    else $error("status field wider than four sources");
  // movement needs a pin change two or three edges back, or a write
  chk_pos_still: assert property (!$stable(position_o) |-> $past(bus_i.wr) || $past(pins_i) != $past(pins_i, 2)
    || $past(pins_i, 2) != $past(pins_i, 3))
    else $error("position moved without cause");
  chk_dir_still: assert property ($changed(direction_o) |-> $past(pins_i) != $past(pins_i, 2)
    || $past(pins_i, 2) != $past(pins_i, 3))
    else $error("direction changed while stationary");
  chk_off_hold: assert property (!en_reg && !$past(en_reg) && !$past(en_reg, 2) && !$past(bus_i.wr)
    |-> $stable(position_o))
    else $error("counting while encoder disabled");
  // two raw reads in a row: the later one keeps every bit of the first
  chk_raw_sticky: assert property (bus_i.rd && bus_i.addr == 8'h28 ##1 bus_i.rd && bus_i.addr == 8'h28
    |=> (rdata_o & $past(rdata_o)) == $past(rdata_o))
    else $error("raw status bit dropped without clear");
endmodule : qepv_asserts
bind qei_core qepv_asserts #(.PRED_W(PRED_W)) u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
  .rdata_o(rdata_o), .pins_i(pins_i), .irq_o(irq_o), .direction_o(direction_o), .position_o(position_o));
`default_nettype wire

// ### verification/quad_encoder_position_velocity_tb.sv
`timescale 1ns/10ps
`default_nettype none
// register-level tests of the encoder core
module quad_encoder_position_velocity_tb;
  import qei_pkg::*;
  logic         clock_i  = 1'b0; // 100 MHz
  logic         rst_n_i  = 1'b0; // reset, active low
  qei_bus_req_s bus      = '0;   // register requests
  wire          qei_enc_in_s pins;
  logic [31:0]  rdata_o, position_o, seen, v, p;
  logic         irq_o, direction_o, d;
  logic         step_man = 1'b0, rev = 1'b0, idx = 1'b0, glitch = 1'b0, run = 1'b0, phase = 1'b0;
  logic [1:0]   tick     = 2'h0; // background step pacing
  logic [7:0]   offc [2] = '{8'h09, 8'h02}; // capture off, encoder off
  int           bad_count = 0, cmp_count = 0;
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i) tick <= tick + 2'h1;
  qei_core u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata_o), .pins_i(pins),
    .irq_o(irq_o), .direction_o(direction_o), .position_o(position_o));
  // background steps every fourth cycle keep velocity counts exact
  qepv_enc_model u_enc (.clock_i(clock_i), .phase_mode_i(phase), .step_i(step_man | (run && tick == 2'h0)),
    .rev_i(rev), .glitch_i(glitch), .index_i(idx), .pins_o(pins));
  task automatic check_eq(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check_eq
  // one request, read data taken in its single valid cycle
  task automatic bus_op(input logic [7:0] a, input logic [31:0] dt, input logic w, input int n);
    @(posedge clock_i);
    bus <= '{a, dt, w, !w};
    repeat (n) @(posedge clock_i);
    bus <= '0;
    #1 seen = rdata_o;
  endtask : bus_op
  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    bus_op(a, dt, 1'b1, 1);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus_op(a, 32'h0, 1'b0, 1);
    check_eq(seen, e);
  endtask : rchk
  task automatic move(input int n, input logic r);
    @(posedge clock_i);
    rev <= r;
    repeat (n) begin
      @(posedge clock_i);
      step_man <= 1'b1;
      @(posedge clock_i);
      step_man <= 1'b0;
      repeat (6) @(posedge clock_i);
    end
  endtask : move
  // index pulse, or a glitch on both phases
  task automatic poke(input logic g);
    @(posedge clock_i);
    idx <= !g;
    glitch <= g;
    @(posedge clock_i);
    idx <= 1'b0;
    glitch <= 1'b0;
    repeat (6) @(posedge clock_i);
  endtask : poke
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  // watchdog, about four times the expected run
  initial begin
    #300000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rchk(8'h00, 32'h0);
    rchk(8'h0C, 32'hFFFFFFFF);
    rchk(8'h14, 32'h1);
    rchk(8'h28, 32'h0);
    rchk(8'h40, 32'h0);
    wr(8'h00, 32'h09);
    wr(8'h08, 32'h10);
    rchk(8'h08, 32'h10);
    move(3, 1'b0);
    rchk(8'h08, 32'h13);
    move(1, 1'b1);
    rchk(8'h08, 32'h12);
    repeat (20) @(posedge clock_i);
    check_eq({31'h0, direction_o}, 32'h1);
    wr(8'h0C, 32'h3F);
    wr(8'h00, 32'h0D);
    wr(8'h08, 32'h5);
    move(1, 1'b0);
    rchk(8'h08, 32'h6);
    poke(1'b0);
    rchk(8'h08, 32'h0);
    move(2, 1'b1);
    rchk(8'h08, 32'h3E);
    poke(1'b0);
    rchk(8'h08, 32'h3F);
    phase <= 1'b1;
    wr(8'h00, 32'h01);
    p = position_o;
    move(4, 1'b0);
    check_eq({31'h0, position_o != p}, 32'h1);
    d = direction_o;
    move(4, 1'b1);
    check_eq({31'h0, direction_o != d}, 32'h1);
    // both channels counted: four edges, each one count
    wr(8'h00, 32'h11);
    move(4, 1'b0);
    rchk(8'h08, 32'h3B);
    // swapped channels flip the sense of the same motion
    wr(8'h00, 32'h31);
    move(4, 1'b0);
    rchk(8'h08, 32'h3F);
    poke(1'b1);
    bus_op(8'h04, 32'h0, 1'b0, 1);
    check_eq({31'h0, seen[0]}, 32'h1);
    wr(8'h04, 32'h1);
    bus_op(8'h04, 32'h0, 1'b0, 1);
    check_eq({31'h0, seen[0]}, 32'h0);
    phase <= 1'b0;
    rev <= 1'b0;
    run <= 1'b1;
    // each predivide code sees exactly two divided counts per period
    for (int c = 0; c < 8; c++) begin
      wr(8'h00, 32'h09);
      wr(8'h10, c);
      wr(8'h14, 32'h8 << c);
      wr(8'h00, 32'h0B);
      repeat (24 << c) @(posedge clock_i);
      rchk(8'h18, 32'h2);
    end
    foreach (offc[i]) begin
      wr(8'h00, {24'h0, offc[i]});
      bus_op(8'h1C, 32'h0, 1'b0, 1);
      v = seen;
      repeat (40) @(posedge clock_i);
      rchk(8'h1C, v);
    end
    run <= 1'b0;
    wr(8'h00, 32'h0);
    rchk(8'h28, 32'hF);
    bus_op(8'h28, 32'h0, 1'b0, 2);
    wr(8'h20, 32'h2);
    rchk(8'h2C, 32'h2);
    check_eq({31'h0, irq_o}, 32'h1);
    wr(8'h24, 32'h2);
    rchk(8'h2C, 32'h0);
    check_eq({31'h0, irq_o}, 32'h0);
    rchk(8'h20, 32'h0);
    wr(8'h20, 32'h2);
    wr(8'h30, 32'h2);
    rchk(8'h28, 32'hD);
    rchk(8'h2C, 32'h0);
    check_eq({31'h0, irq_o}, 32'h0);
    wr(8'h30, 32'hD);
    rchk(8'h28, 32'h0);
    tally_and_finish();
  end
endmodule : quad_encoder_position_velocity_tb
`default_nettype wire
